// [core/iep_pkg.sv]
// Package for the interrupt enable and priority bank: register map, field positions and encodings.
// Assumes an 8-bit register file reached over a classic Wishbone slave with 32-bit data.
`default_nettype none
package iep_pkg;
    // Register byte offsets on the bus.
    localparam logic [4:0] IEP_OFF_ENABLE_MAIN  = 5'h00;
    localparam logic [4:0] IEP_OFF_ENABLE_EXT_A = 5'h04;
    localparam logic [4:0] IEP_OFF_ENABLE_EXT_B = 5'h08;
    localparam logic [4:0] IEP_OFF_PRIORITY_0   = 5'h0c;
    localparam logic [4:0] IEP_OFF_PRIORITY_1   = 5'h10;
    localparam logic [4:0] IEP_OFF_PRIORITY_2   = 5'h14;
    localparam logic [4:0] IEP_OFF_PRIORITY_3   = 5'h18;
    localparam logic [4:0] IEP_OFF_PRIORITY_4   = 5'h1c;
    // Status register: in-progress levels and current grant.
    localparam logic [5:0] IEP_OFF_STATUS       = 6'h20;

    localparam logic [7:0] IEP_RESET_VALUE      = 8'h00;
    // Writable bits of each register; the rest read zero.
    localparam logic [7:0] IEP_MASK_ENABLE_MAIN  = 8'hff;
    localparam logic [7:0] IEP_MASK_ENABLE_EXT_A = 8'hf7;
    localparam logic [7:0] IEP_MASK_ENABLE_EXT_B = 8'h03;
    localparam logic [7:0] IEP_MASK_PRIORITY_3   = 8'hcf;
    localparam logic [7:0] IEP_MASK_PRIORITY_4   = 8'h3f;

    // Enable bit positions in the main enable register.
    localparam int IEP_BIT_GLOBAL_GATE   = 7;
    localparam int IEP_BIT_UART_TWO      = 6;
    localparam int IEP_BIT_WATCHDOG      = 5;
    localparam int IEP_BIT_UART_ONE      = 4;
    localparam int IEP_BIT_TIMER1        = 3;
    localparam int IEP_BIT_EXT_LINE1     = 2;
    localparam int IEP_BIT_TIMER0        = 1;
    localparam int IEP_BIT_EXT_LINE0     = 0;
    // Extension register A.
    localparam int IEP_BIT_GROUP_8TO15   = 7;
    localparam int IEP_BIT_GROUP_2TO7    = 6;
    localparam int IEP_BIT_CONVERTER     = 5;
    localparam int IEP_BIT_TIMER5        = 4;
    localparam int IEP_BIT_TIMER4        = 2;
    localparam int IEP_BIT_TIMER3        = 1;
    localparam int IEP_BIT_SERIAL_PERIPH = 0;
    // Extension register B.
    localparam int IEP_BIT_PORT2_FALL    = 1;
    localparam int IEP_BIT_GROUP_8TO17   = 0;

    // Source indices, in fixed polling order (lower index polled first).
    localparam int IEP_NUM_SRC     = 18;
    localparam int IEP_SRC_EXT0    = 0;
    localparam int IEP_SRC_TIMER0  = 1;
    localparam int IEP_SRC_EXT1    = 2;
    localparam int IEP_SRC_TIMER1  = 3;
    localparam int IEP_SRC_UART1   = 4;
    localparam int IEP_SRC_WDT     = 5;
    localparam int IEP_SRC_LVD     = 6;
    localparam int IEP_SRC_UART2   = 7;
    localparam int IEP_SRC_SPI     = 8;
    localparam int IEP_SRC_TWOWIRE = 9;
    localparam int IEP_SRC_TIMER3  = 10;
    localparam int IEP_SRC_TIMER4  = 11;
    localparam int IEP_SRC_PWM     = 12;
    localparam int IEP_SRC_TIMER5  = 13;
    localparam int IEP_SRC_ADC     = 14;
    localparam int IEP_SRC_GRP2TO7 = 15;
    localparam int IEP_SRC_GRP8UP  = 16;
    localparam int IEP_SRC_PORT2   = 17;

    typedef enum logic [1:0] {
        IEP_ARB_IDLE  = 2'b00,
        IEP_ARB_OFFER = 2'b01,
        IEP_ARB_ACK   = 2'b11
    } iep_arb_state_t;
endpackage
`default_nettype wire

// [core/iep_arbiter.sv]
// Four-level priority arbiter: picks the first source in polling order at the highest level.
// Assumes requests are already masked by their enables and the global gate.
`timescale 1ns/1ps
`default_nettype none
module iep_arbiter
    import iep_pkg::*;
#(
    parameter int N_SRC = IEP_NUM_SRC
) (
    // Requests and levels
    input  wire logic [N_SRC-1:0]   req_i,
    input  wire logic [2*N_SRC-1:0] level_i,
    // Result
    output logic                    any_o,
    output logic [4:0]              index_o,
    output logic [1:0]              level_o
);
    always_comb begin
        any_o   = 1'b0;
        index_o = 5'h00;
        level_o = 2'h0;
        for (int i = 0; i < N_SRC; i++) begin
            // Strictly greater keeps the earlier polled source on a tie.
            if (req_i[i] && (!any_o || level_i[2*i +: 2] > level_o)) begin
                any_o   = 1'b1;
                index_o = 5'(i);
                level_o = level_i[2*i +: 2];
            end
        end
    end
endmodule
`default_nettype wire

// [core/iep_bank.sv]
// Interrupt enable and priority bank with four-level preemptive arbitration toward the CPU core.
// Assumes a classic Wishbone master with 32-bit data and a CPU that pulses ack and return strobes.
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module iep_bank
    import iep_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Raw interrupt sources, indexed in polling order
    input  wire logic [17:0] src_req_i,
    // CPU core side
    output logic             cpu_irq_o,
    output logic [4:0]       cpu_irq_index_o,
    output logic [1:0]       cpu_irq_level_o,
    input  wire logic        cpu_irq_ack_i,
    input  wire logic        return_from_irq_instr_i
);
    logic [7:0] irq_enable_main_reg;
    logic [7:0] irq_enable_ext_a_reg;
    logic [7:0] irq_enable_ext_b_reg;
    logic [7:0] irq_priority_0_reg;
    logic [7:0] irq_priority_1_reg;
    logic [7:0] irq_priority_2_reg;
    logic [7:0] irq_priority_3_reg;
    logic [7:0] irq_priority_4_reg;
    logic [3:0] active_levels_reg;
    logic [3:0] active_levels_next;
    logic       ack_reg;
    logic [31:0] rdata_reg;
    iep_arb_state_t state_reg;
    iep_arb_state_t state_next;
    logic [4:0] grant_index_reg;
    logic [1:0] grant_level_reg;

    logic       bus_req;
    logic       wr_en;
    logic [17:0] src_enable;
    logic [17:0] masked_req;
    logic [35:0] levels;
    logic       arb_any;
    logic [4:0] arb_index;
    logic [1:0] arb_level;
    logic       preempt_ok;
    logic [2:0] top_active;
    logic       top_valid;

    // One-cycle answer; ack drops for a cycle after each access.
    assign bus_req = cyc_i && stb_i && !ack_reg;
    assign wr_en   = bus_req && we_i && sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end
    assign ack_o = ack_reg;

    // Register writes; the masks keep reserved bits at zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable_main_reg  <= IEP_RESET_VALUE;
            irq_enable_ext_a_reg <= IEP_RESET_VALUE;
            irq_enable_ext_b_reg <= IEP_RESET_VALUE;
            irq_priority_0_reg   <= IEP_RESET_VALUE;
            irq_priority_1_reg   <= IEP_RESET_VALUE;
            irq_priority_2_reg   <= IEP_RESET_VALUE;
            irq_priority_3_reg   <= IEP_RESET_VALUE;
            irq_priority_4_reg   <= IEP_RESET_VALUE;
        end else if (wr_en) begin
            if (adr_i[4:0] == IEP_OFF_ENABLE_MAIN && !adr_i[5]) begin
                irq_enable_main_reg <= dat_i[7:0] & IEP_MASK_ENABLE_MAIN;
            end else if (adr_i[4:0] == IEP_OFF_ENABLE_EXT_A && !adr_i[5]) begin
                irq_enable_ext_a_reg <= dat_i[7:0] & IEP_MASK_ENABLE_EXT_A;
            end else if (adr_i[4:0] == IEP_OFF_ENABLE_EXT_B && !adr_i[5]) begin
                irq_enable_ext_b_reg <= dat_i[7:0] & IEP_MASK_ENABLE_EXT_B;
            end else if (adr_i[4:0] == IEP_OFF_PRIORITY_0 && !adr_i[5]) begin
                irq_priority_0_reg <= dat_i[7:0];
            end else if (adr_i[4:0] == IEP_OFF_PRIORITY_1 && !adr_i[5]) begin
                irq_priority_1_reg <= dat_i[7:0];
            end else if (adr_i[4:0] == IEP_OFF_PRIORITY_2 && !adr_i[5]) begin
                irq_priority_2_reg <= dat_i[7:0];
            end else if (adr_i[4:0] == IEP_OFF_PRIORITY_3 && !adr_i[5]) begin
                irq_priority_3_reg <= dat_i[7:0] & IEP_MASK_PRIORITY_3;
            end else if (adr_i[4:0] == IEP_OFF_PRIORITY_4 && !adr_i[5]) begin
                irq_priority_4_reg <= dat_i[7:0] & IEP_MASK_PRIORITY_4;
            end
        end
    end

    // Read data is captured with the ack; unmapped offsets read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            if (adr_i == {1'b0, IEP_OFF_ENABLE_MAIN}) begin
                rdata_reg <= {24'h000000, irq_enable_main_reg};
            end else if (adr_i == {1'b0, IEP_OFF_ENABLE_EXT_A}) begin
                rdata_reg <= {24'h000000, irq_enable_ext_a_reg};
            end else if (adr_i == {1'b0, IEP_OFF_ENABLE_EXT_B}) begin
                rdata_reg <= {24'h000000, irq_enable_ext_b_reg};
            end else if (adr_i == {1'b0, IEP_OFF_PRIORITY_0}) begin
                rdata_reg <= {24'h000000, irq_priority_0_reg};
            end else if (adr_i == {1'b0, IEP_OFF_PRIORITY_1}) begin
                rdata_reg <= {24'h000000, irq_priority_1_reg};
            end else if (adr_i == {1'b0, IEP_OFF_PRIORITY_2}) begin
                rdata_reg <= {24'h000000, irq_priority_2_reg};
            end else if (adr_i == {1'b0, IEP_OFF_PRIORITY_3}) begin
                rdata_reg <= {24'h000000, irq_priority_3_reg};
            end else if (adr_i == {1'b0, IEP_OFF_PRIORITY_4}) begin
                rdata_reg <= {24'h000000, irq_priority_4_reg};
            end else if (adr_i == IEP_OFF_STATUS) begin
                rdata_reg <= {17'h00000, cpu_irq_o, grant_level_reg, grant_index_reg,
                              3'h0, active_levels_reg};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end
    assign dat_o = rdata_reg;

    // Per-source enables. The low-voltage, two-wire and modulator sources carry
    // their enables in their own peripherals, so they pass here ungated.
    always_comb begin
        src_enable                  = '0;
        src_enable[IEP_SRC_EXT0]    = irq_enable_main_reg[IEP_BIT_EXT_LINE0];
        src_enable[IEP_SRC_TIMER0]  = irq_enable_main_reg[IEP_BIT_TIMER0];
        src_enable[IEP_SRC_EXT1]    = irq_enable_main_reg[IEP_BIT_EXT_LINE1];
        src_enable[IEP_SRC_TIMER1]  = irq_enable_main_reg[IEP_BIT_TIMER1];
        src_enable[IEP_SRC_UART1]   = irq_enable_main_reg[IEP_BIT_UART_ONE];
        src_enable[IEP_SRC_WDT]     = irq_enable_main_reg[IEP_BIT_WATCHDOG];
        src_enable[IEP_SRC_LVD]     = 1'b1;
        src_enable[IEP_SRC_UART2]   = irq_enable_main_reg[IEP_BIT_UART_TWO];
        src_enable[IEP_SRC_SPI]     = irq_enable_ext_a_reg[IEP_BIT_SERIAL_PERIPH];
        src_enable[IEP_SRC_TWOWIRE] = 1'b1;
        src_enable[IEP_SRC_TIMER3]  = irq_enable_ext_a_reg[IEP_BIT_TIMER3];
        src_enable[IEP_SRC_TIMER4]  = irq_enable_ext_a_reg[IEP_BIT_TIMER4];
        src_enable[IEP_SRC_PWM]     = 1'b1;
        src_enable[IEP_SRC_TIMER5]  = irq_enable_ext_a_reg[IEP_BIT_TIMER5];
        src_enable[IEP_SRC_ADC]     = irq_enable_ext_a_reg[IEP_BIT_CONVERTER];
        src_enable[IEP_SRC_GRP2TO7] = irq_enable_ext_a_reg[IEP_BIT_GROUP_2TO7];
        // Either group bit opens the shared 8-and-up vector.
        src_enable[IEP_SRC_GRP8UP]  = irq_enable_ext_a_reg[IEP_BIT_GROUP_8TO15]
                                    | irq_enable_ext_b_reg[IEP_BIT_GROUP_8TO17];
        src_enable[IEP_SRC_PORT2]   = irq_enable_ext_b_reg[IEP_BIT_PORT2_FALL];
    end

    // The global gate blocks everything toward the core.
    assign masked_req = src_req_i & src_enable & {18{irq_enable_main_reg[IEP_BIT_GLOBAL_GATE]}};

    // Priority fields, two bits per source index.
    always_comb begin
        levels                          = '0;
        levels[2*IEP_SRC_EXT0 +: 2]    = irq_priority_0_reg[1:0];
        levels[2*IEP_SRC_TIMER0 +: 2]  = irq_priority_0_reg[3:2];
        levels[2*IEP_SRC_EXT1 +: 2]    = irq_priority_0_reg[5:4];
        levels[2*IEP_SRC_TIMER1 +: 2]  = irq_priority_0_reg[7:6];
        levels[2*IEP_SRC_UART1 +: 2]   = irq_priority_1_reg[1:0];
        levels[2*IEP_SRC_WDT +: 2]     = irq_priority_1_reg[3:2];
        levels[2*IEP_SRC_LVD +: 2]     = irq_priority_1_reg[5:4];
        levels[2*IEP_SRC_UART2 +: 2]   = irq_priority_1_reg[7:6];
        levels[2*IEP_SRC_SPI +: 2]     = irq_priority_2_reg[1:0];
        levels[2*IEP_SRC_TWOWIRE +: 2] = irq_priority_2_reg[3:2];
        levels[2*IEP_SRC_TIMER3 +: 2]  = irq_priority_2_reg[5:4];
        levels[2*IEP_SRC_TIMER4 +: 2]  = irq_priority_2_reg[7:6];
        levels[2*IEP_SRC_PWM +: 2]     = irq_priority_3_reg[1:0];
        levels[2*IEP_SRC_TIMER5 +: 2]  = irq_priority_3_reg[3:2];
        levels[2*IEP_SRC_ADC +: 2]     = irq_priority_3_reg[7:6];
        levels[2*IEP_SRC_GRP2TO7 +: 2] = irq_priority_4_reg[1:0];
        levels[2*IEP_SRC_GRP8UP +: 2]  = irq_priority_4_reg[3:2];
        levels[2*IEP_SRC_PORT2 +: 2]   = irq_priority_4_reg[5:4];
    end

    iep_arbiter #(
        .N_SRC   (IEP_NUM_SRC)
    ) u_arbiter (
        .req_i   (masked_req),
        .level_i (levels),
        .any_o   (arb_any),
        .index_o (arb_index),
        .level_o (arb_level)
    );

    // Highest level now in service.
    always_comb begin
        top_valid  = 1'b0;
        top_active = 3'h0;
        for (int l = 0; l < 4; l++) begin
            if (active_levels_reg[l]) begin
                top_valid  = 1'b1;
                top_active = 3'(l);
            end
        end
    end

    // Only a strictly higher level may preempt.
    assign preempt_ok = arb_any && (!top_valid || {1'b0, arb_level} > top_active);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IEP_ARB_IDLE: begin
                if (preempt_ok) begin
                    state_next = IEP_ARB_OFFER;
                end
            end
            IEP_ARB_OFFER: begin
                if (cpu_irq_ack_i) begin
                    state_next = IEP_ARB_ACK;
                end else if (!preempt_ok) begin
                    state_next = IEP_ARB_IDLE;
                end
            end
            IEP_ARB_ACK: begin
                state_next = IEP_ARB_IDLE;
            end
            default: begin
                state_next = IEP_ARB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= IEP_ARB_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // The offered grant follows the arbiter while unacknowledged.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            grant_index_reg <= 5'h00;
            grant_level_reg <= 2'h0;
        end else if (state_reg != IEP_ARB_ACK && preempt_ok) begin
            grant_index_reg <= arb_index;
            grant_level_reg <= arb_level;
        end
    end

    // Ack marks the level in progress; only the return-from-irq strobe clears
    // the highest one, so a plain return leaves it blocking.
    always_comb begin
        active_levels_next = active_levels_reg;
        if (return_from_irq_instr_i && top_valid) begin
            active_levels_next[top_active[1:0]] = 1'b0;
        end
        if (state_reg == IEP_ARB_OFFER && cpu_irq_ack_i) begin
            active_levels_next[grant_level_reg] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_levels_reg <= 4'h0;
        end else begin
            active_levels_reg <= active_levels_next;
        end
    end

    assign cpu_irq_o       = (state_reg == IEP_ARB_OFFER);
    assign cpu_irq_index_o = grant_index_reg;
    assign cpu_irq_level_o = grant_level_reg;
endmodule
`default_nettype wire

// [bench/iep_bank_asserts.sv]
// Checker for the enable and priority bank: gate, offers, preemption and read masks.
// Assumes it is bound to iep_bank and sees only its ports, on one clock.
`timescale 1ns/1ps
`default_nettype none
module iep_bank_asserts
    import iep_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [5:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [17:0] src_req_i,
    input wire logic        cpu_irq_o,
    input wire logic [4:0]  cpu_irq_index_o,
    input wire logic [1:0]  cpu_irq_level_o,
    input wire logic        cpu_irq_ack_i,
    input wire logic        return_from_irq_instr_i
);
    logic        take;
    logic [2:0]  top;
    logic        gate_reg;
    logic        rd_reg;
    logic [5:0]  adr_reg;
    logic [17:0] src_reg;
    logic [3:0]  act_reg;
    assign take = cyc_i && stb_i && !ack_o;
    // Top level in service plus one, so that zero means nothing is in service.
    assign top = act_reg[3] ? 3'h4 : act_reg[2] ? 3'h3 : act_reg[1] ? 3'h2 : act_reg[0] ? 3'h1 : 3'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_reg <= 1'b0;
        end else if (take && we_i && sel_i[0] && adr_i == {1'b0, IEP_OFF_ENABLE_MAIN}) begin
            gate_reg <= dat_i[IEP_BIT_GLOBAL_GATE];
        end
    end
    always_ff @(posedge clk_i) begin
        if (take) begin
            rd_reg  <= !we_i;
            adr_reg <= adr_i;
        end
    end
    always_ff @(posedge clk_i) begin
        src_reg <= src_req_i;
    end
    // A return clears the top level before a simultaneous take marks a new one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_reg <= 4'h0;
        end else begin
            act_reg <= (return_from_irq_instr_i ? act_reg & ~(4'h1 << (top - 3'h1)) : act_reg)
                       | ((cpu_irq_ack_i && cpu_irq_o) ? 4'h1 << cpu_irq_level_o : 4'h0);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_gate_blocks: assert property (!gate_reg && !$past(gate_reg) |-> !cpu_irq_o)
        else $error("offer made while the global gate is off");
    a_offer_source: assert property ($rose(cpu_irq_o) |-> src_reg[cpu_irq_index_o])
        else $error("offered source was not requesting");
    a_take_ends_offer: assert property (cpu_irq_o && cpu_irq_ack_i |=> !cpu_irq_o)
        else $error("offer still stands after it was taken");
    a_only_higher: assert property (cpu_irq_o |-> {1'b0, cpu_irq_level_o} + 3'h1 > top)
        else $error("offer not above the level in service");
    a_ext_a_rsvd: assert property (ack_o && rd_reg && adr_reg == {1'b0, IEP_OFF_ENABLE_EXT_A}
        |-> dat_o[3] == 1'b0)
        else $error("reserved enable bit reads one");
    a_ext_b_rsvd: assert property (ack_o && rd_reg && adr_reg == {1'b0, IEP_OFF_ENABLE_EXT_B}
        |-> dat_o[7:2] == 6'h00)
        else $error("read-only enable bits read nonzero");
    a_prio3_rsvd: assert property (ack_o && rd_reg && adr_reg == {1'b0, IEP_OFF_PRIORITY_3}
        |-> dat_o[5:4] == 2'h0)
        else $error("reserved priority field reads nonzero");
    a_prio4_rsvd: assert property (ack_o && rd_reg && adr_reg == {1'b0, IEP_OFF_PRIORITY_4}
        |-> dat_o[7:6] == 2'h0)
        else $error("reserved priority field reads nonzero");
    a_upper_zero: assert property (ack_o && rd_reg && adr_reg != IEP_OFF_STATUS |-> dat_o[31:8] == 24'h0)
        else $error("unused read bits are nonzero");
    a_unmapped_zero: assert property (ack_o && rd_reg && adr_reg > 6'h20 |-> dat_o == 32'h0)
        else $error("unmapped read returned data");
endmodule
bind iep_bank iep_bank_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .src_req_i(src_req_i), .cpu_irq_o(cpu_irq_o), .cpu_irq_index_o(cpu_irq_index_o),
    .cpu_irq_level_o(cpu_irq_level_o), .cpu_irq_ack_i(cpu_irq_ack_i),
    .return_from_irq_instr_i(return_from_irq_instr_i));
`default_nettype wire

// [bench/iep_cpu_model.sv]
// Behavioural CPU core: takes a standing offer after a chosen delay and strobes returns.
// Assumes the bench enables taking and requests each return.
`timescale 1ns/1ps
`default_nettype none
module iep_cpu_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       irq_i,
    input  wire logic       take_en_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       ret_req_i,
    output logic            ack_o,
    output logic            ret_o
);
    logic [3:0] wait_reg;
    logic       ack_reg;
    // An offer withdrawn meanwhile is never taken.
    assign ack_o = ack_reg && irq_i;
    always_ff @(posedge clk_i) begin
        if (rst_i || !irq_i || ack_reg) begin
            wait_reg <= 4'h0;
            ack_reg  <= 1'b0;
        end else if (take_en_i) begin
            if (wait_reg == delay_i) begin
                ack_reg <= 1'b1;
            end else begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
    // Levels are released only by this return strobe; the model has no plain return.
    always_ff @(posedge clk_i) begin
        ret_o <= ret_req_i && !rst_i;
    end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the enable and priority bank with a CPU core model.
// Assumes the bank answers each bus cycle with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import iep_pkg::*;
    typedef struct packed { logic [5:0] a; logic [7:0] w; logic [7:0] e; } iep_row_t;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cpu_irq_o, cpu_ack, ret, take_en, ret_req;
    logic [5:0]  adr_i;
    logic [3:0]  sel_i, delay;
    logic [31:0] dat_i, dat_o, q;
    logic [17:0] src_req_i;
    logic [4:0]  idx;
    logic [1:0]  lvl;
    int errors, num_checks;
    iep_row_t rows[10] = '{'{6'h00, 8'hff, 8'hff}, '{6'h04, 8'hff, 8'hf7}, '{6'h08, 8'hff, 8'h03},
        '{6'h0c, 8'ha5, 8'ha5}, '{6'h10, 8'h5a, 8'h5a}, '{6'h14, 8'hc3, 8'hc3}, '{6'h18, 8'hff, 8'hcf},
        '{6'h1c, 8'hff, 8'h3f}, '{6'h24, 8'hff, 8'h00}, '{6'h3c, 8'hff, 8'h00}};
    int eb[16] = '{0, 1, 2, 3, 4, 5, 6, 0, 1, 2, 4, 5, 6, 7, 0, 1};
    int es[16] = '{0, 1, 2, 3, 4, 5, 7, 8, 10, 11, 13, 14, 15, 16, 16, 17};
    int pa[5] = '{'h10, 'h14, 'h18, 'h1c, 'h1c};
    int pv[5] = '{'h10, 'h08, 'hc0, 'h20, 'h08};
    int ps[5] = '{6, 9, 14, 17, 16};
    int pl[5] = '{1, 2, 3, 2, 2};
    iep_bank dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .src_req_i(src_req_i),
        .cpu_irq_o(cpu_irq_o), .cpu_irq_index_o(idx), .cpu_irq_level_o(lvl), .cpu_irq_ack_i(cpu_ack),
        .return_from_irq_instr_i(ret));
    iep_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_i(cpu_irq_o), .take_en_i(take_en),
        .delay_i(delay), .ret_req_i(ret_req), .ack_o(cpu_ack), .ret_o(ret));
    always #10 clk_i = ~clk_i;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) begin
            check("bus ack", 32'(ack_o), 32'h1);
            print_verdict();
        end
    endtask
    task automatic wr(input int a, input int d);
        bus(6'(a), 1'b1, 8'(d), 4'hf);
    endtask
    task automatic wait_irq(input logic want);
        int n;
        n = 0;
        while (cpu_irq_o !== want && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40) begin
            check("offer", 32'(cpu_irq_o), 32'(want));
            print_verdict();
        end
    endtask
    task automatic idle_check(input string name);
        repeat (4) @(posedge clk_i);
        check(name, 32'(cpu_irq_o), 32'h0);
    endtask
    task automatic ret_pulse();
        ret_req <= 1'b1;
        @(posedge clk_i);
        ret_req <= 1'b0;
    endtask
    initial begin
        {clk_i, cyc_i, stb_i, we_i, take_en, ret_req, adr_i, sel_i, dat_i, src_req_i} = '0;
        rst_i = 1'b1;
        delay = 4'h2;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            bus(rows[i].a, 1'b0, 8'h00, 4'hf);
            check("reset value", q, 32'h0);
        end
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].a, rows[i].w);
            bus(rows[i].a, 1'b0, 8'h00, 4'hf);
            check("readback", q, {24'h0, rows[i].e});
        end
        bus(6'h00, 1'b1, 8'h00, 4'he);
        bus(6'h00, 1'b0, 8'h00, 4'hf);
        check("lane refused", q, 32'hff);
        $display("test registers done");
        wr('h00, 'h7f);
        src_req_i <= '1;
        idle_check("gate off");
        wr('h00, 'hff);
        wait_irq(1'b1);
        check("top level index", 32'(idx), 32'd8);
        check("top level", 32'(lvl), 32'd3);
        src_req_i <= '0;
        wait_irq(1'b0);
        for (int a = 'h0c; a <= 'h1c; a += 4) wr(a, 0);
        src_req_i <= 18'h00003;
        wait_irq(1'b1);
        check("poll order", 32'(idx), 32'd0);
        take_en <= 1'b1;
        wait_irq(1'b0);
        take_en <= 1'b0;
        idle_check("equal held off");
        wr('h0c, 'hc0);
        src_req_i <= 18'h0000b;
        wait_irq(1'b1);
        check("preempt index", 32'(idx), 32'd3);
        delay <= 4'h0;
        take_en <= 1'b1;
        wait_irq(1'b0);
        take_en <= 1'b0;
        src_req_i <= 18'h00003;
        ret_pulse();
        idle_check("lower still held");
        ret_pulse();
        wait_irq(1'b1);
        check("released index", 32'(idx), 32'd0);
        src_req_i <= '0;
        wait_irq(1'b0);
        $display("test preemption done");
        for (int i = 0; i < 5; i++) begin
            wr(pa[i], pv[i]);
            src_req_i <= 18'h1 << ps[i];
            wait_irq(1'b1);
            check("field index", 32'(idx), 32'(ps[i]));
            check("field level", 32'(lvl), 32'(pl[i]));
            src_req_i <= '0;
            wait_irq(1'b0);
            wr(pa[i], 0);
        end
        $display("test priority fields done");
        for (int i = 0; i < 16; i++) begin
            wr('h04, 0);
            wr('h08, 0);
            wr('h00, 'h80);
            src_req_i <= 18'h1 << es[i];
            idle_check("masked");
            wr(i < 7 ? 0 : (i < 14 ? 4 : 8), (1 << eb[i]) | (i < 7 ? 'h80 : 0));
            wait_irq(1'b1);
            check("enabled index", 32'(idx), 32'(es[i]));
            src_req_i <= '0;
            wait_irq(1'b0);
        end
        $display("test enables done");
        src_req_i <= 18'h20000;
        wait_irq(1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check("reset offer", 32'(cpu_irq_o), 32'h0);
        bus(6'h08, 1'b0, 8'h00, 4'hf);
        check("reset enable", q, 32'h0);
        idle_check("reset gate");
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
